// ### design/converter_cfg.svh
`ifndef CONVERTER_CFG_SVH
`define CONVERTER_CFG_SVH

// ==========================================
// Character widths
`define BAUDOT_BITS 5
`define ASCII_BITS 8
`define ROM_ADDR_BITS 6

// ==========================================
// Output bit positions (b1 is bit 0)
`define OUT_B5_POS 4
`define OUT_B6_POS 5
`define OUT_B7_POS 6
`define OUT_B8_POS 7

// ==========================================
// Shift control entries in the lookup memory
`define FIGURES_LOCK_OPTION_ENTRY 7'h18
`define LTRS_ENTRY 7'h7F

// ==========================================
// Buffer geometry
`define BUF_DEPTH 2

`endif

// ### design/converter_pkg.sv
package converter_pkg;
    // ==========================================
    // Shift case held between characters
    typedef enum logic {
        CASE_LETTERS,
        CASE_FIGURES
    } shift_case_type;
endpackage

// ### design/char_buffer.sv
`timescale 1ns/1ns
`default_nettype none
`include "converter_cfg.svh"

module char_buffer #(
    parameter int WIDTH = `ASCII_BITS,
    parameter int DEPTH = `BUF_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    // ==========================================
    // Handshake
    // Room while the fill level is below the depth; an empty buffer must accept
    assign in_ready = (count_reg < (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];

    // Storage; entries are not reset, only the pointers and the fill level matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Fill level; simultaneous push and pop leave it unchanged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### design/baudot_to_ascii_converter.sv
`timescale 1ns/1ns
`default_nettype none
`include "converter_cfg.svh"

// ==========================================
// Baudot to ASCII converter
// The shift case sits beside the five received bits as a sixth address
// line. Both sides of the block work in mark-low sense, so the core
// inverts on the way in and again on the way out.

module baudot_to_ascii_converter #(
    parameter int BUF_DEPTH = `BUF_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Upstream deserializer, bits 1..5 at [4:0] MSB first, mark is low
    input wire logic [`BAUDOT_BITS-1:0] baudot_n,
    input wire logic strobe,
    output logic in_ready,
    // Options
    input wire logic figures_lock_option,
    input wire logic suppress_shift_option,
    input wire logic parity_select_option,
    // Downstream character buffer, b8..b1 at [7:0], mark is low
    output logic transfer,
    input wire logic out_ready,
    output logic [`ASCII_BITS-1:0] ascii_n,
    // Status
    output converter_pkg::shift_case_type shift_case_bit,
    output logic case_address_input
);
    import converter_pkg::*;

    // ==========================================
    // Lookup memory
    // Entry is 7 ASCII bits plus a parity column in the top bit.
    // The case bit is the top address line, so the letters half fills
    // positions 0 to 31 and the figures half positions 32 to 63.
    // Codes with no 8-level meaning read back as null rather than garbage.
    function automatic logic [6:0] rom_char(input logic [5:0] a);
        logic [6:0] c;
        c = 7'h00;
        case (a)
            // Letters half, case address low
            6'h00: c = 7'h00; // Blank gives null
            6'h02: c = 7'h0D;
            6'h03: c = 7'h4F;
            6'h04: c = 7'h20;
            6'h05: c = 7'h48;
            6'h06: c = 7'h4E;
            6'h07: c = 7'h4D;
            6'h08: c = 7'h0A;
            6'h09: c = 7'h4C;
            6'h0A: c = 7'h52;
            6'h0B: c = 7'h47;
            6'h0C: c = 7'h49;
            6'h0D: c = 7'h50;
            6'h0E: c = 7'h43;
            6'h0F: c = 7'h56;
            6'h10: c = 7'h45;
            6'h11: c = 7'h5A;
            6'h12: c = 7'h44;
            6'h13: c = 7'h42;
            6'h14: c = 7'h53;
            6'h15: c = 7'h59;
            6'h16: c = 7'h46;
            6'h17: c = 7'h58;
            6'h18: c = 7'h41;
            6'h19: c = 7'h57;
            6'h1A: c = 7'h4A;
            6'h1C: c = 7'h55;
            6'h1D: c = 7'h51;
            6'h1E: c = 7'h4B;
            6'h01: c = 7'h54;
            // Figures half, case address high
            6'h20: c = 7'h00; // Blank gives null here too
            6'h21: c = 7'h35;
            6'h22: c = 7'h0D;
            6'h23: c = 7'h39;
            6'h24: c = 7'h20;
            6'h25: c = 7'h23;
            6'h26: c = 7'h2C;
            6'h27: c = 7'h2E;
            6'h28: c = 7'h0A;
            6'h29: c = 7'h29;
            6'h2A: c = 7'h34;
            6'h2B: c = 7'h26;
            6'h2C: c = 7'h38;
            6'h2D: c = 7'h30;
            6'h2E: c = 7'h3A;
            6'h2F: c = 7'h3B;
            6'h30: c = 7'h33;
            6'h31: c = 7'h22;
            6'h32: c = 7'h24;
            6'h33: c = 7'h3F;
            6'h34: c = 7'h07;
            6'h35: c = 7'h36;
            6'h36: c = 7'h21;
            6'h37: c = 7'h2F;
            6'h38: c = 7'h2D;
            6'h39: c = 7'h32;
            6'h3A: c = 7'h27;
            6'h3C: c = 7'h37;
            6'h3D: c = 7'h31;
            6'h3E: c = 7'h28;
            // Shift characters repeat in both halves so the decoders always see them
            6'h1B, 6'h3B: c = `FIGURES_LOCK_OPTION_ENTRY;
            6'h1F, 6'h3F: c = `LTRS_ENTRY;
            default: c = 7'h00;
        endcase
        return c;
    endfunction

    // Parity column: odd parity in the letters half, space in the figures half
    // Selecting parity therefore gives a space bit for every figures character.
    function automatic logic [7:0] rom_entry(input logic [5:0] a);
        logic [6:0] c;
        c = rom_char(a);
        return {(a[5] ? 1'b0 : ~^c), c};
    endfunction

    // Built once as a constant table; synthesis folds it into logic.
    // One entry per case and character, so the depth follows the address width.
    localparam int ROM_DEPTH = 1 << `ROM_ADDR_BITS;
    logic [`ASCII_BITS-1:0] rom [ROM_DEPTH];
    for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_rom
        assign rom[i] = rom_entry(6'(i));
    end

    // ==========================================
    // Address and lookup
    // Case state and the lookup path
    shift_case_type case_reg;
    logic [`BAUDOT_BITS-1:0] baudot_true;
    logic [`ROM_ADDR_BITS-1:0] rom_addr;
    logic [`ASCII_BITS-1:0] rom_out;
    logic figures_lock_option_det;
    logic ltrs_det;
    logic push;
    logic [`ASCII_BITS-1:0] out_true;
    logic [`ASCII_BITS-1:0] buf_out;

    // Inputs arrive mark-low; restore true sense before addressing
    assign baudot_true = ~baudot_n;
    // Lock clamps the case input regardless of the stored case
    assign case_address_input = figures_lock_option || (case_reg == CASE_FIGURES);
    // Bit 1 lands on the top character address line
    assign rom_addr = {case_address_input, baudot_true};
    assign rom_out = rom[rom_addr];

    // ==========================================
    // Shift character decoders, gated by the strobe
    // The decoders look at the lookup output, not the raw code, so a
    // reprogrammed table moves the shift characters with it.
    // The strobe gate keeps half-shifted bits from faking a shift code.
    assign figures_lock_option_det = strobe && rom_out[`OUT_B5_POS] && !rom_out[`OUT_B6_POS]
                      && !rom_out[`OUT_B7_POS];
    assign ltrs_det = strobe && rom_out[`OUT_B6_POS] && rom_out[`OUT_B7_POS];

    // Case store; a lock does not disturb it, so unlocking resumes the old case
    // Both decoders cannot fire together, so the order of the branches is free.
    // Reset picks letters, the case a teleprinter also starts in.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            case_reg <= CASE_LETTERS;
        end else if (figures_lock_option_det) begin
            case_reg <= CASE_FIGURES;
        end else if (ltrs_det) begin
            case_reg <= CASE_LETTERS;
        end
    end
    // Status shows the stored case; a lock shows only on case_address_input
    assign shift_case_bit = case_reg;

    // ==========================================
    // Transfer into the buffer
    // A strobe while in_ready is low loses the character; upstream must wait.
    // The case still follows a dropped shift character, as the decoders
    // do not look at the buffer.
    assign push = strobe && !(suppress_shift_option && (figures_lock_option_det || ltrs_det));
    // Eighth bit: constant mark, or the parity column when selected
    assign out_true = {parity_select_option ? rom_out[`OUT_B8_POS] : 1'b1,
                       rom_out[`OUT_B8_POS-1:0]};

    // Two entries let the far side stall for a word time without loss,
    // while the next character is already converted and waiting.
    char_buffer #(
        .WIDTH(`ASCII_BITS),
        .DEPTH(BUF_DEPTH)
    ) i_char_buffer (
        .clk(clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(in_ready),
        .in_data(out_true),
        .out_valid(transfer),
        .out_ready(out_ready),
        .out_data(buf_out)
    );

    // Output back to mark-low sense
    // The inverter sits after the buffer flops, so no extra cycle is spent.
    assign ascii_n = ~buf_out;
endmodule
`default_nettype wire

// ### dv/char_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Downstream character buffer model
module char_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Converter side
    input wire logic transfer,
    input wire logic [7:0] ascii_n,
    output logic out_ready,
    // Bench side
    input wire logic stall,
    output logic [7:0] word_reg,
    output int word_cnt
);
    // Accept unless the bench asks for a stall
    assign out_ready = !stall;
    // Words kept inverted, as on the wire, so the bench sees real levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_cnt <= 0;
        end else if (transfer && out_ready) begin
            word_reg <= ascii_n;
            word_cnt <= word_cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ### dv/converter_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Port checks for the converter
module converter_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Upstream and options
    input wire logic [4:0] baudot_n,
    input wire logic strobe,
    input wire logic in_ready,
    input wire logic figures_lock_option,
    input wire logic suppress_shift_option,
    input wire logic parity_select_option,
    // Downstream and status
    input wire logic transfer,
    input wire logic out_ready,
    input wire logic [7:0] ascii_n,
    input wire converter_pkg::shift_case_type shift_case_bit,
    input wire logic case_address_input
);
    import converter_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Shift characters as seen at the inverted input pins
    logic is_shift;
    assign is_shift = baudot_n == 5'h04 || baudot_n == 5'h00;
    sequence s_figures_lock_option; strobe && baudot_n == 5'h04; endsequence
    sequence s_ltrs; strobe && baudot_n == 5'h00; endsequence
    property p_figures_lock_option; s_figures_lock_option |=> shift_case_bit == CASE_FIGURES; endproperty
    property p_ltrs; s_ltrs |=> shift_case_bit == CASE_LETTERS; endproperty
    property p_idle; !strobe |=> $stable(shift_case_bit); endproperty
    property p_keep; strobe && !is_shift |=> $stable(shift_case_bit); endproperty
    property p_addr;
        case_address_input == (figures_lock_option || shift_case_bit == CASE_FIGURES);
    endproperty
    property p_drop;
        strobe && suppress_shift_option && is_shift && !transfer |=> !transfer;
    endproperty
    property p_pass;
        strobe && in_ready && !transfer && !(suppress_shift_option && is_shift) |=> transfer;
    endproperty
    property p_hold; transfer && !out_ready |=> transfer && $stable(ascii_n); endproperty
    a_figures_lock_option: assert property (p_figures_lock_option) else $error("figures not stored");
    a_ltrs: assert property (p_ltrs) else $error("letters not stored");
    a_idle: assert property (p_idle) else $error("case moved without strobe");
    a_keep: assert property (p_keep) else $error("case moved on plain char");
    a_addr: assert property (p_addr) else $error("case address wrong");
    a_drop: assert property (p_drop) else $error("shift char passed");
    a_pass: assert property (p_pass) else $error("char not offered");
    a_hold: assert property (p_hold) else $error("word not held");
endmodule
bind baudot_to_ascii_converter converter_asserts i_converter_asserts (.clk, .rst,
    .baudot_n, .strobe, .in_ready, .figures_lock_option, .suppress_shift_option,
    .parity_select_option, .transfer, .out_ready, .ascii_n, .shift_case_bit,
    .case_address_input);
`default_nettype wire

// ### dv/baudot_to_ascii_converter_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ========
// Converter bench
module baudot_to_ascii_converter_tb;
    import converter_pkg::*;
    logic clk = 0, rst = 1, strobe = 0, stall = 0, in_ready, transfer, out_ready;
    logic figures_lock_option = 0, suppress_shift_option = 0, parity_select_option = 0;
    logic case_address_input;
    logic [4:0] baudot_n = 5'h1F;
    logic [7:0] ascii_n, word_reg;
    shift_case_type shift_case_bit;
    int word_cnt, error_cnt = 0, n_compared = 0, n0;
    baudot_to_ascii_converter i_baudot_to_ascii_converter (.clk, .rst, .baudot_n, .strobe,
        .in_ready, .figures_lock_option, .suppress_shift_option, .parity_select_option,
        .transfer, .out_ready, .ascii_n, .shift_case_bit, .case_address_input);
    char_sink i_char_sink (.clk, .rst, .transfer, .ascii_n, .out_ready, .stall,
        .word_reg, .word_cnt);
    // Free running 20 MHz clock
    always #25 clk = ~clk;
    // ========
    // Helpers
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One strobe per character, inputs moved just after the edge
    task automatic send(input logic [4:0] code);
        @(posedge clk) #5;
        baudot_n = code;
        strobe = 1;
        @(posedge clk) #5;
        strobe = 0;
    endtask
    // Bounded wait, so a lost word cannot hang the run
    task automatic conv(input logic [4:0] code, input logic [7:0] exp, input bit word);
        n0 = word_cnt;
        send(code);
        for (int i = 0; i < 20 && word_cnt == n0; i++) @(posedge clk) #5;
        if (word && word_cnt == n0) begin
            error_cnt++;
            $display("mismatch at %0t: no word within limit", $time);
            stop_test();
        end else if (word) begin
            check(word_reg, exp);
        end else begin
            check(8'(word_cnt - n0), 8'h00);
        end
    endtask
    // ========
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #5 rst = 0;
        check(shift_case_bit, CASE_LETTERS);
        check({in_ready, transfer}, 8'h02);
        conv(5'h1E, 8'h2B, 1);
        // Stall far side: two words fit, third is refused
        stall = 1;
        n0 = word_cnt;
        send(5'h1E);
        send(5'h0F);
        check(in_ready, 8'h00);
        send(5'h1C);
        stall = 0;
        @(posedge clk) #1 check(word_reg, 8'h2B);
        @(posedge clk) #1 check(word_reg, 8'h3A);
        repeat (3) @(posedge clk);
        check(8'(word_cnt - n0), 8'h02);
        conv(5'h04, 8'h67, 1);
        check({shift_case_bit, case_address_input}, 8'h03);
        parity_select_option = 1;
        conv(5'h1E, 8'hCA, 1);
        check(shift_case_bit, CASE_FIGURES);
        parity_select_option = 0;
        suppress_shift_option = 1;
        conv(5'h00, 8'h00, 0);
        check(shift_case_bit, CASE_LETTERS);
        // Figures code on the pins with no strobe must not move the case
        baudot_n = 5'h04;
        repeat (4) @(posedge clk);
        check(shift_case_bit, CASE_LETTERS);
        figures_lock_option = 1;
        #1 check(case_address_input, 8'h01);
        conv(5'h1E, 8'h4A, 1);
        check(shift_case_bit, CASE_LETTERS);
        stop_test();
    end
endmodule
`default_nettype wire
